//--- spcf_framer.sv
// Notes on behaviour
// [RULE1] a character is one start bit, eight data bits, parity, stop bits
// [RULE2] six bit rates from 1200 to 38400 are selectable
// [RULE3] no, odd or even parity is generated and checked
// [RULE4] one or two stop bits by configuration
// [RULE5] the host must use exactly the configured rate, parity and stops
// [RULE6] a message is head E9, address, length, payload, check byte
// [RULE7] after the head, E8 is sent as E8 00 and E9 as E8 01
// [RULE8] after the head, E8 00 becomes E8 and E8 01 becomes E9
// [RULE9] an escaped pair counts as one byte in the length
// [RULE10] address is one byte, 1 to 30; only own address accepted
// [RULE11] length byte counts the payload bytes that follow
// [RULE12] check byte is XOR of address, length and unescaped payload
// [RULE13] payload is a command code followed by its data
// [RULE14] set-speed is 57 4A, speed word, run byte, direction byte
// [RULE15] speed is unsigned 16 bit, 0.01 rpm units, high byte first
// [RULE16] run byte bit 0 starts or stops, bit 1 selects full speed
// [RULE17] direction byte bit 0 set is clockwise, clear counter-clockwise
// [RULE18] an accepted set-speed command switches the display to speed
// [RULE19] commands act only in remote serial control mode
// [RULE20] after power-up the pump is stopped until a command starts it
// [RULE21] bytes outside a head-flagged frame go to the other protocol
// [RULE22] a valid set-speed command is answered with its code alone
// [RULE23] bad check byte or short payload discards the frame silently
module spcf_framer #(
  parameter int unsigned CLK_HZ_P = spcf_pkg::CLK_HZ
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic rs485_rx_in,
  output logic rs485_tx_out,
  output logic rs485_de_out,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [2:0] cfg_baud_in,
  input wire logic [1:0] cfg_parity_in,
  input wire logic cfg_stop2_in,
  input wire logic remote_serial_control_mode_in,
  output logic [15:0] speed_out,
  output logic run_out,
  output logic full_speed_out,
  output logic clockwise_out,
  output logic display_speed_out,
  output logic set_speed_command_out,
  output logic [7:0] other_byte_out,
  output logic other_byte_valid_out
);
  localparam logic [16:0] DIV_1200 = 17'(CLK_HZ_P / spcf_pkg::BAUD_1200);
  localparam logic [16:0] DIV_2400 = 17'(CLK_HZ_P / spcf_pkg::BAUD_2400);
  localparam logic [16:0] DIV_4800 = 17'(CLK_HZ_P / spcf_pkg::BAUD_4800);
  localparam logic [16:0] DIV_9600 = 17'(CLK_HZ_P / spcf_pkg::BAUD_9600);
  localparam logic [16:0] DIV_19200 = 17'(CLK_HZ_P / spcf_pkg::BAUD_19200);
  localparam logic [16:0] DIV_38400 = 17'(CLK_HZ_P / spcf_pkg::BAUD_38400);

  logic [16:0] bit_div;
  logic [7:0] rx_byte;
  logic rx_valid, rx_err, tx_ready;

  always_comb begin
    case (cfg_baud_in) // [RULE2]
      spcf_pkg::BSEL_1200: bit_div = DIV_1200;
      spcf_pkg::BSEL_2400: bit_div = DIV_2400;
      spcf_pkg::BSEL_4800: bit_div = DIV_4800;
      spcf_pkg::BSEL_19200: bit_div = DIV_19200;
      spcf_pkg::BSEL_38400: bit_div = DIV_38400;
      default: bit_div = DIV_9600;
    endcase
  end

  // the host must match these settings; nothing here adapts to it [RULE5]
  spcf_uart_rx u_rx (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .rx_pin_in(rs485_rx_in),
    .bit_div_in(bit_div),
    .parity_in(cfg_parity_in),
    .byte_out(rx_byte),
    .byte_valid_out(rx_valid),
    .byte_err_out(rx_err)
  );

  // receive parsing
  spcf_pkg::spcf_parse_t ps_reg, ps_next;
  logic esc_reg, esc_next;
  logic [7:0] addr_reg, addr_next, len_reg, len_next;
  logic [7:0] xor_reg, xor_next, pcnt_reg, pcnt_next;
  logic [7:0] pl_reg [spcf_pkg::PL_N];
  logic [7:0] pl_next [spcf_pkg::PL_N];
  logic [7:0] ub;
  logic ub_valid, cmd_ok, act;
  logic [7:0] oth_next;
  logic oth_valid_next;

  always_comb begin
    ps_next = ps_reg;
    esc_next = esc_reg;
    addr_next = addr_reg;
    len_next = len_reg;
    xor_next = xor_reg;
    pcnt_next = pcnt_reg;
    pl_next = pl_reg;
    ub = rx_byte;
    ub_valid = 1'b0;
    cmd_ok = 1'b0;
    oth_next = other_byte_out;
    oth_valid_next = 1'b0;
    if (rx_valid) begin
      if (rx_err) begin
        ps_next = spcf_pkg::P_HUNT; // [RULE23]
        esc_next = 1'b0;
      end else if (rx_byte == spcf_pkg::FLAG_HEAD) begin
        // a head cuts short any frame still open: its payload was short
        ps_next = spcf_pkg::P_ADDR; // [RULE6] [RULE23]
        esc_next = 1'b0;
      end else if (ps_reg == spcf_pkg::P_HUNT) begin
        oth_next = rx_byte; // [RULE21]
        oth_valid_next = 1'b1;
      end else if (esc_reg) begin
        esc_next = 1'b0;
        ub_valid = 1'b1;
        if (rx_byte == spcf_pkg::ESC_OF_E8) begin
          ub = spcf_pkg::ESC_BYTE; // [RULE8]
        end else if (rx_byte == spcf_pkg::ESC_OF_E9) begin
          ub = spcf_pkg::FLAG_HEAD; // [RULE8]
        end else begin
          ub_valid = 1'b0;
          ps_next = spcf_pkg::P_HUNT;
        end
      end else if (rx_byte == spcf_pkg::ESC_BYTE) begin
        esc_next = 1'b1;
      end else begin
        ub_valid = 1'b1;
      end
    end
    if (ub_valid) begin
      case (ps_reg)
        spcf_pkg::P_ADDR: begin
          addr_next = ub;
          xor_next = ub;
          ps_next = spcf_pkg::P_LEN;
        end
        spcf_pkg::P_LEN: begin
          len_next = ub; // [RULE11]
          xor_next = xor_reg ^ ub;
          pcnt_next = 8'h00;
          ps_next = (ub == 8'h00) ? spcf_pkg::P_FCS : spcf_pkg::P_PAY;
        end
        spcf_pkg::P_PAY: begin
          if (pcnt_reg < 8'(spcf_pkg::PL_N)) begin
            pl_next[pcnt_reg[2:0]] = ub; // [RULE13]
          end
          xor_next = xor_reg ^ ub;
          // one count per restored byte, so escapes never stretch it
          pcnt_next = pcnt_reg + 8'h01; // [RULE9]
          if (pcnt_next == len_reg) begin
            ps_next = spcf_pkg::P_FCS;
          end
        end
        spcf_pkg::P_FCS: begin
          ps_next = spcf_pkg::P_HUNT;
          cmd_ok = (ub == xor_reg) && // [RULE12] [RULE23]
            (addr_reg == cfg_addr_in) && // [RULE10]
            (addr_reg >= spcf_pkg::ADDR_MIN) &&
            (addr_reg <= spcf_pkg::ADDR_MAX) &&
            (len_reg == spcf_pkg::SET_SPEED_LEN) &&
            (pl_reg[spcf_pkg::PL_CMD_HI] == spcf_pkg::CMD_HI) && // [RULE14]
            (pl_reg[spcf_pkg::PL_CMD_LO] == spcf_pkg::CMD_LO);
        end
        default: ps_next = spcf_pkg::P_HUNT;
      endcase
    end
  end

  assign act = cmd_ok && remote_serial_control_mode_in; // [RULE19]

  // pump state
  logic [15:0] speed_next;
  logic run_next, full_next, cw_next, disp_next;

  always_comb begin
    speed_next = speed_out;
    run_next = run_out;
    full_next = full_speed_out;
    cw_next = clockwise_out;
    disp_next = display_speed_out;
    if (act) begin
      speed_next = {pl_reg[spcf_pkg::PL_SPD_HI],
                    pl_reg[spcf_pkg::PL_SPD_LO]}; // [RULE15]
      run_next = pl_reg[spcf_pkg::PL_RUN][spcf_pkg::RUN_BIT]; // [RULE16]
      full_next = pl_reg[spcf_pkg::PL_RUN][spcf_pkg::FULL_BIT]; // [RULE16]
      cw_next = pl_reg[spcf_pkg::PL_DIR][spcf_pkg::CW_BIT]; // [RULE17]
      disp_next = 1'b1; // [RULE18]
    end
  end

  // reply emitter: head, address, length, code, check byte
  logic em_busy_reg, em_busy_next, em_pend_reg, em_pend_next;
  logic [2:0] em_idx_reg, em_idx_next;
  logic [7:0] em_pbyte_reg, em_pbyte_next, rep_addr_reg, rep_addr_next;
  logic [7:0] em_byte, wr_data;
  logic wr_req;
  logic [7:0] fifo_reg [2];
  logic fifo_wp_reg, fifo_rp_reg;
  logic [1:0] fifo_cnt_reg;
  logic fifo_full, fifo_rd, fifo_wr;

  assign fifo_full = (fifo_cnt_reg == 2'h2);

  always_comb begin
    case (em_idx_reg)
      3'h0: em_byte = spcf_pkg::FLAG_HEAD; // [RULE6] [RULE22]
      3'h1: em_byte = rep_addr_reg;
      3'h2: em_byte = spcf_pkg::REPLY_LEN;
      3'h3: em_byte = spcf_pkg::CMD_HI;
      3'h4: em_byte = spcf_pkg::CMD_LO;
      default: em_byte = rep_addr_reg ^ spcf_pkg::REPLY_LEN ^
                         spcf_pkg::CMD_HI ^ spcf_pkg::CMD_LO; // [RULE12]
    endcase
  end

  always_comb begin
    em_busy_next = em_busy_reg;
    em_pend_next = em_pend_reg;
    em_idx_next = em_idx_reg;
    em_pbyte_next = em_pbyte_reg;
    rep_addr_next = rep_addr_reg;
    wr_req = 1'b0;
    wr_data = em_byte;
    if (!em_busy_reg) begin
      // a command arriving during a reply still acts but gets no answer
      if (act) begin
        em_busy_next = 1'b1;
        em_idx_next = 3'h0;
        rep_addr_next = addr_reg;
      end
    end else if (!fifo_full) begin
      wr_req = 1'b1;
      if (em_pend_reg) begin
        wr_data = em_pbyte_reg;
        em_pend_next = 1'b0;
      end else if (em_idx_reg != 3'h0 &&
                   (em_byte == spcf_pkg::ESC_BYTE ||
                    em_byte == spcf_pkg::FLAG_HEAD)) begin
        wr_data = spcf_pkg::ESC_BYTE; // [RULE7]
        em_pend_next = 1'b1;
        em_pbyte_next = (em_byte == spcf_pkg::ESC_BYTE) ?
                        spcf_pkg::ESC_OF_E8 : spcf_pkg::ESC_OF_E9;
      end
      if (!em_pend_next) begin
        em_idx_next = em_idx_reg + 3'h1;
        em_busy_next = (em_idx_reg != spcf_pkg::REPLY_LAST);
      end
    end
  end

  // two-entry buffer: the serialiser stalls it, the emitter waits on full
  assign fifo_wr = wr_req;
  assign fifo_rd = tx_ready && (fifo_cnt_reg != 2'h0);

  spcf_uart_tx u_tx (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .bit_div_in(bit_div),
    .parity_in(cfg_parity_in),
    .stop2_in(cfg_stop2_in),
    .data_in(fifo_reg[fifo_rp_reg]),
    .valid_in(fifo_cnt_reg != 2'h0),
    .ready_out(tx_ready),
    .tx_out(rs485_tx_out)
  );

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ps_reg <= spcf_pkg::P_HUNT;
      esc_reg <= 1'b0;
      addr_reg <= 8'h00;
      len_reg <= 8'h00;
      xor_reg <= 8'h00;
      pcnt_reg <= 8'h00;
      for (int i = 0; i < spcf_pkg::PL_N; i++) pl_reg[i] <= 8'h00;
      speed_out <= 16'h0000;
      run_out <= 1'b0; // [RULE20]
      full_speed_out <= 1'b0;
      clockwise_out <= 1'b0;
      display_speed_out <= 1'b0;
      set_speed_command_out <= 1'b0;
      other_byte_out <= 8'h00;
      other_byte_valid_out <= 1'b0;
      em_busy_reg <= 1'b0;
      em_pend_reg <= 1'b0;
      em_idx_reg <= 3'h0;
      em_pbyte_reg <= 8'h00;
      rep_addr_reg <= 8'h00;
      fifo_reg[0] <= 8'h00;
      fifo_reg[1] <= 8'h00;
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      rs485_de_out <= 1'b0;
    end else begin
      ps_reg <= ps_next;
      esc_reg <= esc_next;
      addr_reg <= addr_next;
      len_reg <= len_next;
      xor_reg <= xor_next;
      pcnt_reg <= pcnt_next;
      pl_reg <= pl_next;
      speed_out <= speed_next;
      run_out <= run_next;
      full_speed_out <= full_next;
      clockwise_out <= cw_next;
      display_speed_out <= disp_next;
      set_speed_command_out <= act;
      other_byte_out <= oth_next;
      other_byte_valid_out <= oth_valid_next;
      em_busy_reg <= em_busy_next;
      em_pend_reg <= em_pend_next;
      em_idx_reg <= em_idx_next;
      em_pbyte_reg <= em_pbyte_next;
      rep_addr_reg <= rep_addr_next;
      if (fifo_wr) fifo_reg[fifo_wp_reg] <= wr_data;
      fifo_wp_reg <= fifo_wp_reg ^ fifo_wr;
      fifo_rp_reg <= fifo_rp_reg ^ fifo_rd;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_wr} - {1'b0, fifo_rd};
      rs485_de_out <= em_busy_next || fifo_wr ||
                      (fifo_cnt_reg != 2'h0) || !tx_ready;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  sequence esc_written_s;
    fifo_wr && wr_data == spcf_pkg::ESC_BYTE && em_idx_reg != 3'h0;
  endsequence
  sequence pair_tail_s;
    em_pend_reg && (em_pbyte_reg == spcf_pkg::ESC_OF_E8 ||
                    em_pbyte_reg == spcf_pkg::ESC_OF_E9);
  endsequence

  reply_head_a: assert property ( // [RULE6]
    !em_busy_reg && !fifo_full && act |=>
      fifo_wr && wr_data == spcf_pkg::FLAG_HEAD)
    else $error("reply does not start with head byte");
  stuff_pair_a: assert property (esc_written_s |=> pair_tail_s) // [RULE7]
    else $error("escape byte not followed by its code");
  unstuff_a: assert property ( // [RULE8]
    rx_valid && !rx_err && esc_reg && ps_reg != spcf_pkg::P_HUNT &&
    rx_byte == spcf_pkg::ESC_OF_E9 |-> ub_valid && ub == spcf_pkg::FLAG_HEAD)
    else $error("escaped head not restored");
  own_addr_a: assert property ( // [RULE10]
    set_speed_command_out |-> $past(addr_reg) == $past(cfg_addr_in))
    else $error("command accepted for another address");
  run_bits_a: assert property ( // [RULE16]
    act |=> run_out == $past(pl_reg[spcf_pkg::PL_RUN][0]) &&
            full_speed_out == $past(pl_reg[spcf_pkg::PL_RUN][1]))
    else $error("run or full speed not taken from command");
  direction_a: assert property ( // [RULE17]
    act |=> clockwise_out == $past(pl_reg[spcf_pkg::PL_DIR][0]))
    else $error("direction not taken from command");
  display_speed_a: assert property (act |=> display_speed_out) // [RULE18]
    else $error("display not switched to speed");
  local_ignore_a: assert property ( // [RULE19]
    !remote_serial_control_mode_in |=> $stable(speed_out) && $stable(run_out))
    else $error("command acted on outside remote mode");
  stop_at_reset_a: assert property ($fell(srst_in) |-> !run_out) // [RULE20]
    else $error("pump not stopped after reset");
  bad_check_a: assert property ( // [RULE23]
    ub_valid && ps_reg == spcf_pkg::P_FCS && ub != xor_reg |=>
      !set_speed_command_out && !$rose(em_busy_reg))
    else $error("frame with bad check byte acted on");
endmodule

//--- spcf_framer_tb_top.sv
module spcf_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CLK_P = 1000000;
  localparam int unsigned RATES[3] = '{spcf_pkg::BAUD_9600,
    spcf_pkg::BAUD_19200, spcf_pkg::BAUD_38400};
  logic mclk_in, srst_in, rx_line, tx_line, de, cfg_stop2, remote;
  logic [7:0] cfg_addr, ob, last_ob;
  logic [2:0] cfg_baud;
  logic [1:0] cfg_par;
  logic [15:0] speed;
  logic run, full, cw, disp, pulse, ob_v;
  logic [spcf_pkg::DIV_W-1:0] div;
  int fails = 0;
  int num_checks = 0;
  int pulses = 0;
  int obs = 0;
  spcf_framer #(.CLK_HZ_P(CLK_P)) spcf_framer_i (.mclk_in(mclk_in),
    .srst_in(srst_in), .rs485_rx_in(rx_line), .rs485_tx_out(tx_line),
    .rs485_de_out(de), .cfg_addr_in(cfg_addr), .cfg_baud_in(cfg_baud),
    .cfg_parity_in(cfg_par), .cfg_stop2_in(cfg_stop2),
    .remote_serial_control_mode_in(remote), .speed_out(speed),
    .run_out(run), .full_speed_out(full), .clockwise_out(cw),
    .display_speed_out(disp), .set_speed_command_out(pulse),
    .other_byte_out(ob), .other_byte_valid_out(ob_v));
  spcf_host_model spcf_host_model_i (.mclk_in(mclk_in),
    .rs485_tx_in(tx_line), .rs485_de_in(de), .par_in(cfg_par),
    .stop2_in(cfg_stop2), .div_in(div), .line_out(rx_line));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (pulse === 1'b1) pulses <= pulses + 1;
    if (ob_v === 1'b1) begin
      obs <= obs + 1;
      last_ob <= ob;
    end
  end
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic send_frame(input logic [7:0] a, input logic [15:0] spd,
      input logic [7:0] rb, input logic [7:0] fx);
    logic [7:0] b[$];
    logic [7:0] f;
    // bit 2 of rb doubles as the direction bit
    b = '{a, 8'h06, 8'h57, 8'h4a, spd[15:8], spd[7:0], rb, {7'h00, rb[2]}};
    f = 8'h00;
    foreach (b[i]) f ^= b[i];
    b.push_back(f ^ fx);
    @(posedge mclk_in);
    spcf_host_model_i.send_byte(8'he9);
    foreach (b[i]) begin
      if (b[i] == 8'he8 || b[i] == 8'he9) begin
        spcf_host_model_i.send_byte(8'he8);
        spcf_host_model_i.send_byte({7'h00, b[i][0]});
      end else spcf_host_model_i.send_byte(b[i]);
    end
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic get_reply(input logic [7:0] a);
    logic [7:0] exp[$];
    int n;
    logic [7:0] g;
    exp = '{8'he9, a, 8'h02, 8'h57, 8'h4a, a ^ 8'h1f};
    n = 0;
    while (spcf_host_model_i.rxq.size() < 6 && n < 20000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n == 20000) begin
      fails++;
      close_out();
    end else begin
      foreach (exp[i]) begin
        g = spcf_host_model_i.rxq.pop_front();
        check({12'h0, g}, {12'h0, exp[i]});
      end
      check({19'h0, spcf_host_model_i.perr}, 20'h0);
    end
  endtask
  initial begin
    int p0;
    srst_in = 1'b1;
    cfg_addr = 8'h01;
    cfg_baud = 3'h4;
    cfg_par = spcf_pkg::PAR_NONE;
    cfg_stop2 = 1'b0;
    remote = 1'b1;
    div = 17'(CLK_P / RATES[0]);
    repeat (12) @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    check({speed, run, full, cw, disp}, 20'h0);
    for (int k = 0; k < 3; k++) begin
      cfg_baud <= 3'h4 + 3'(k);
      cfg_par <= 2'h1 + 2'(k);
      cfg_stop2 <= k[0];
      div <= 17'(CLK_P / RATES[k]);
      p0 = pulses;
      send_frame(8'h01, 16'h1388, 8'h05, 8'h00);
      check({speed, run, full, cw, disp}, {16'h1388, 4'hb});
      check(20'(pulses - p0), 20'h1);
      get_reply(8'h01);
    end
    // top address, both escapes inside the speed word
    cfg_addr <= 8'h1e;
    send_frame(8'h1e, 16'he8e9, 8'h03, 8'h00);
    check({speed, run, full, cw, disp}, {16'he8e9, 4'hd});
    get_reply(8'h1e);
    for (int k = 0; k < 3; k++) begin
      remote <= (k != 2);
      p0 = pulses;
      send_frame(k == 1 ? 8'h01 : 8'h1e, 16'h0001, 8'h00, {7'h0, k == 0});
      repeat (1500) @(posedge mclk_in);
      check({speed, run, full, cw, disp}, {16'he8e9, 4'hd});
      check(20'(pulses - p0 + spcf_host_model_i.rxq.size()), 20'h0);
    end
    p0 = obs;
    @(posedge mclk_in);
    spcf_host_model_i.send_byte(8'h03);
    repeat (3) @(posedge mclk_in);
    check({12'h0, last_ob}, 20'h3);
    check(20'(obs - p0), 20'h1);
    close_out();
  end
  initial begin
    repeat (100000) @(posedge mclk_in);
    fails++;
    close_out();
  end
endmodule

//--- spcf_host_model.sv
module spcf_host_model (
  input wire logic mclk_in,
  input wire logic rs485_tx_in,
  input wire logic rs485_de_in,
  input wire logic [1:0] par_in,
  input wire logic stop2_in,
  input wire logic [spcf_pkg::DIV_W-1:0] div_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rxq[$];
  logic [7:0] sh;
  logic perr = 1'b0;
  logic odd;
  initial line_out = 1'b1;
  assign odd = par_in == spcf_pkg::PAR_ODD;
  task automatic put_bit(input logic b);
    line_out <= b;
    repeat (div_in) @(posedge mclk_in);
  endtask
  // always the pump's own format; a mismatched host is not modelled
  task automatic send_byte(input logic [7:0] d);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (par_in > spcf_pkg::PAR_NONE) put_bit(odd ? ~^d : ^d);
    put_bit(1'b1);
    if (stop2_in) put_bit(1'b1);
  endtask
  // mid-bit sampling tolerates the floor in the divisor
  always begin
    @(posedge mclk_in);
    if (rs485_de_in && !rs485_tx_in) begin
      repeat (div_in / 2) @(posedge mclk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (div_in) @(posedge mclk_in);
        sh[i] = rs485_tx_in;
      end
      if (par_in > spcf_pkg::PAR_NONE) begin
        repeat (div_in) @(posedge mclk_in);
        if (rs485_tx_in !== (odd ? ~^sh : ^sh)) perr = 1'b1;
      end
      repeat (div_in) @(posedge mclk_in);
      if (rs485_tx_in !== 1'b1) perr = 1'b1;
      rxq.push_back(sh);
    end
  end
endmodule

//--- spcf_pkg.sv
package spcf_pkg;
  // device clock and serial rates
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int DIV_W = 17;
  // rate select codes, same encoding as the set-parameters command
  localparam logic [2:0] BSEL_1200 = 3'h1;
  localparam logic [2:0] BSEL_2400 = 3'h2;
  localparam logic [2:0] BSEL_4800 = 3'h3;
  localparam logic [2:0] BSEL_9600 = 3'h4;
  localparam logic [2:0] BSEL_19200 = 3'h5;
  localparam logic [2:0] BSEL_38400 = 3'h6;
  localparam logic [1:0] PAR_NONE = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // framing bytes
  localparam logic [7:0] FLAG_HEAD = 8'he9;
  localparam logic [7:0] ESC_BYTE = 8'he8;
  localparam logic [7:0] ESC_OF_E8 = 8'h00;
  localparam logic [7:0] ESC_OF_E9 = 8'h01;
  localparam logic [7:0] CMD_HI = 8'h57;
  localparam logic [7:0] CMD_LO = 8'h4a;
  localparam logic [7:0] SET_SPEED_LEN = 8'h06;
  localparam logic [7:0] REPLY_LEN = 8'h02;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'h1e;
  // payload positions and bit fields
  localparam int PL_N = 6;
  localparam int PL_CMD_HI = 0;
  localparam int PL_CMD_LO = 1;
  localparam int PL_SPD_HI = 2;
  localparam int PL_SPD_LO = 3;
  localparam int PL_RUN = 4;
  localparam int PL_DIR = 5;
  localparam int RUN_BIT = 0;
  localparam int FULL_BIT = 1;
  localparam int CW_BIT = 0;
  localparam logic [2:0] REPLY_LAST = 3'h5;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b11, RX_STOP = 2'b10
  } spcf_rx_t;
  typedef enum logic [2:0] {
    P_HUNT = 3'b000, P_ADDR = 3'b001, P_LEN = 3'b011,
    P_PAY = 3'b010, P_FCS = 3'b110
  } spcf_parse_t;
endpackage

//--- spcf_uart_rx.sv
module spcf_uart_rx (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic rx_pin_in,
  input wire logic [spcf_pkg::DIV_W-1:0] bit_div_in,
  input wire logic [1:0] parity_in,
  output logic [7:0] byte_out,
  output logic byte_valid_out,
  output logic byte_err_out
);
  logic s1_reg, s2_reg;
  spcf_pkg::spcf_rx_t st_reg, st_next;
  logic [spcf_pkg::DIV_W-1:0] cnt_reg, cnt_next;
  logic [3:0] bitn_reg, bitn_next;
  logic [8:0] sh_reg, sh_next;
  logic [7:0] byte_next;
  logic valid_next, err_next, has_par;
  logic [7:0] data;

  assign has_par = (parity_in == spcf_pkg::PAR_ODD) ||
                   (parity_in == spcf_pkg::PAR_EVEN);
  // without parity the eight data bits end up one place higher
  assign data = has_par ? sh_reg[7:0] : sh_reg[8:1];

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bitn_next = bitn_reg;
    sh_next = sh_reg;
    byte_next = byte_out;
    valid_next = 1'b0;
    err_next = 1'b0;
    case (st_reg)
      spcf_pkg::RX_IDLE: if (!s2_reg) begin // [RULE1]
        st_next = spcf_pkg::RX_START;
        cnt_next = bit_div_in >> 1;
      end
      spcf_pkg::RX_START: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          st_next = s2_reg ? spcf_pkg::RX_IDLE : spcf_pkg::RX_BITS;
          cnt_next = bit_div_in - 1'b1;
          bitn_next = 4'h0;
        end
      end
      spcf_pkg::RX_BITS: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          sh_next = {s2_reg, sh_reg[8:1]};
          bitn_next = bitn_reg + 1'b1;
          cnt_next = bit_div_in - 1'b1;
          if (bitn_reg == (has_par ? 4'h8 : 4'h7)) begin // [RULE1] [RULE3]
            st_next = spcf_pkg::RX_STOP;
          end
        end
      end
      spcf_pkg::RX_STOP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          // only the first stop bit is checked; a second one is line idle
          st_next = spcf_pkg::RX_IDLE;
          valid_next = 1'b1;
          byte_next = data;
          err_next = !s2_reg ||
            (parity_in == spcf_pkg::PAR_ODD && !(^sh_reg)) || // [RULE3]
            (parity_in == spcf_pkg::PAR_EVEN && (^sh_reg));
        end
      end
      default: st_next = spcf_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    s1_reg <= rx_pin_in;
    s2_reg <= s1_reg;
    if (srst_in) begin
      st_reg <= spcf_pkg::RX_IDLE;
      cnt_reg <= '0;
      bitn_reg <= 4'h0;
      sh_reg <= 9'h000;
      byte_out <= 8'h00;
      byte_valid_out <= 1'b0;
      byte_err_out <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bitn_reg <= bitn_next;
      sh_reg <= sh_next;
      byte_out <= byte_next;
      byte_valid_out <= valid_next;
      byte_err_out <= err_next;
    end
  end
endmodule

//--- spcf_uart_tx.sv
module spcf_uart_tx (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [spcf_pkg::DIV_W-1:0] bit_div_in,
  input wire logic [1:0] parity_in,
  input wire logic stop2_in,
  input wire logic [7:0] data_in,
  input wire logic valid_in,
  output logic ready_out,
  output logic tx_out
);
  logic [10:0] sh_reg, sh_next;
  logic [3:0] left_reg, left_next;
  logic [spcf_pkg::DIV_W-1:0] cnt_reg, cnt_next;
  logic tx_next, has_par, pbit;

  assign ready_out = (left_reg == 4'h0);
  assign has_par = (parity_in == spcf_pkg::PAR_ODD) ||
                   (parity_in == spcf_pkg::PAR_EVEN);
  assign pbit = (parity_in == spcf_pkg::PAR_ODD) ? !(^data_in) : ^data_in;

  always_comb begin
    sh_next = sh_reg;
    left_next = left_reg;
    cnt_next = cnt_reg;
    tx_next = tx_out;
    if (left_reg == 4'h0) begin
      tx_next = 1'b1;
      if (valid_in) begin
        // start, data lsb first, parity, then one or two stop bits
        sh_next = {2'b11, has_par ? pbit : 1'b1, data_in}; // [RULE1] [RULE3]
        tx_next = 1'b0;
        left_next = 4'ha + {3'h0, has_par} + {3'h0, stop2_in}; // [RULE4]
        cnt_next = bit_div_in - 1'b1;
      end
    end else begin
      cnt_next = cnt_reg - 1'b1;
      if (cnt_reg == '0) begin
        left_next = left_reg - 1'b1;
        cnt_next = bit_div_in - 1'b1;
        tx_next = (left_reg == 4'h1) ? 1'b1 : sh_reg[0];
        sh_next = {1'b1, sh_reg[10:1]};
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sh_reg <= 11'h7ff;
      left_reg <= 4'h0;
      cnt_reg <= '0;
      tx_out <= 1'b1;
    end else begin
      sh_reg <= sh_next;
      left_reg <= left_next;
      cnt_reg <= cnt_next;
      tx_out <= tx_next;
    end
  end
endmodule
